// ===== common/isv_pkg.sv
package isv_pkg;
   localparam int CLK_HZ = 125_000_000;
   localparam int TICK_CYCLES_DEF = CLK_HZ;
   localparam int NO_VALUE_SEC = 10;
   localparam int AVG_LONG_SEC = 10;
   localparam int ERR_HEAT_SEC = 3;
   localparam int HEAT_OFF_SEC = 10;
   localparam int REF_REACQ_SEC = 15;
   localparam int RESTART_DELAY_SEC = 3;
   localparam int BOOT_EXTRA_MS = 200;
   localparam int BOOT_EXTRA_CYCLES_DEF = CLK_HZ / 1000 * BOOT_EXTRA_MS;
   localparam int SECONDS_PER_HOUR = 3600;
   localparam int HOURS_WRAP = 100_000;
   localparam logic signed [15:0] HEAT_ON_TEMP_C10 = 16'sh0014;
   localparam logic signed [15:0] HEAT_OFF_TEMP_C10 = 16'sh0046;
   localparam logic [2:0] FILL_LOW_LIMIT = 3'h2;
   localparam logic [2:0] FILL_FULL_LIMIT = 3'h7;
   localparam int MIN_AUX_AVG_MS = 600;
   localparam logic [1:0] HEAT_OFF = 2'h0;
   localparam logic [1:0] HEAT_AUTO = 2'h1;
   localparam logic [1:0] HEAT_ON = 2'h2;
   localparam logic [1:0] AUX_NONE = 2'h0;
   localparam logic [1:0] AUX_HEAT_GATE = 2'h1;
   localparam logic [1:0] AUX_FULL_FLAG = 2'h2;
   localparam int EV_START = 0;
   localparam int EV_CONFIG = 1;
   localparam int EV_REFREG = 2;
   localparam int EV_NODATA = 3;
   localparam int EV_LOWFILL = 4;
   localparam int EV_COUNT = 5;
   localparam int HOURS_W = 17;
   localparam logic [2:0] BOOT_LOADER_BUS = 3'h0;
   localparam logic [2:0] BOOT_FAST_1 = 3'h1;
   localparam logic [2:0] BOOT_FAST_2 = 3'h2;
   localparam logic [2:0] BOOT_LOADER_XMODEM = 3'h3;
   localparam logic [1:0] LOG_HEADER = 2'h0;
   localparam logic [1:0] LOG_MASK = 2'h1;
   localparam logic [1:0] LOG_ENTRY = 2'h2;
   localparam logic [1:0] LOG_END = 2'h3;
   typedef enum {ISV_BOOT_HOLD, ISV_BOOT_DELAY, ISV_BOOT_LOADER, ISV_BOOT_APP} isv_boot_e;
   typedef enum {ISV_RD_IDLE, ISV_RD_HEAD, ISV_RD_MASK, ISV_RD_ENTRY, ISV_RD_END} isv_rd_e;
endpackage

// ===== common/isv_log_if.sv
`timescale 1ns/1ps
interface isv_log_if #(parameter int HOURS_W = 17);
   logic wr_en;
   logic [2:0] wr_code;
   logic [HOURS_W-1:0] wr_hours;
   logic rd_start;
   logic rd_ready;
   logic rd_valid;
   logic [1:0] rd_kind;
   logic [2:0] rd_code;
   logic [HOURS_W-1:0] rd_hours;
   modport owner (output wr_en, wr_code, wr_hours, rd_start, rd_ready, input rd_valid, rd_kind, rd_code, rd_hours);
   modport store (input wr_en, wr_code, wr_hours, rd_start, rd_ready, output rd_valid, rd_kind, rd_code, rd_hours);
endinterface

// ===== rtl/isv_event_log.sv
`timescale 1ns/1ps
module isv_event_log
   import isv_pkg::*;
#(
   parameter int DEPTH = 16
)(
   input wire logic clk,
   input wire logic arst_n,
   isv_log_if.store lg
);
   localparam int AW = $clog2(DEPTH);
   initial begin
      if (DEPTH < 2 || (1 << AW) != DEPTH) $error("DEPTH must be a power of two");
   end
   logic [2:0] code_mem [DEPTH];
   logic [HOURS_W-1:0] hours_mem [DEPTH];
   logic [AW-1:0] wr_ptr_r;
   logic [AW:0] count_r;
   logic [AW-1:0] rd_ptr_r;
   logic [AW:0] rd_left_r;
   isv_rd_e state_r;
   // ----------------------------------------
   // Circular store, oldest overwritten
   // ----------------------------------------
   always_ff @(posedge clk) begin
      if (lg.wr_en) begin
         code_mem[wr_ptr_r] <= lg.wr_code;
         hours_mem[wr_ptr_r] <= lg.wr_hours;
      end
   end
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         wr_ptr_r <= '0;
         count_r <= '0;
      end else if (lg.wr_en) begin
         wr_ptr_r <= wr_ptr_r + 1'b1;
         if (count_r != (AW+1)'(DEPTH)) count_r <= count_r + 1'b1;
      end
   end
   // ----------------------------------------
   // Read-out sequence
   // ----------------------------------------
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         state_r <= ISV_RD_IDLE;
         rd_ptr_r <= '0;
         rd_left_r <= '0;
      end else begin
         case (state_r)
            ISV_RD_IDLE: if (lg.rd_start) state_r <= ISV_RD_HEAD;
            ISV_RD_HEAD: if (lg.rd_ready) begin
               state_r <= ISV_RD_MASK;
               rd_ptr_r <= wr_ptr_r - count_r[AW-1:0];
               rd_left_r <= count_r;
            end
            ISV_RD_MASK: if (lg.rd_ready) state_r <= (rd_left_r == '0) ? ISV_RD_END : ISV_RD_ENTRY;
            ISV_RD_ENTRY: if (lg.rd_ready) begin
               rd_ptr_r <= rd_ptr_r + 1'b1;
               rd_left_r <= rd_left_r - 1'b1;
               if (rd_left_r == (AW+1)'(1)) state_r <= ISV_RD_END;
            end
            ISV_RD_END: if (lg.rd_ready) state_r <= ISV_RD_IDLE;
            default: state_r <= ISV_RD_IDLE;
         endcase
      end
   end
   always_comb begin
      lg.rd_valid = (state_r != ISV_RD_IDLE);
      lg.rd_code = 3'h0;
      lg.rd_hours = '0;
      case (state_r)
         ISV_RD_HEAD: lg.rd_kind = LOG_HEADER;
         ISV_RD_MASK: lg.rd_kind = LOG_MASK;
         ISV_RD_ENTRY: begin
            lg.rd_kind = LOG_ENTRY;
            lg.rd_code = code_mem[rd_ptr_r];
            lg.rd_hours = hours_mem[rd_ptr_r];
         end
         ISV_RD_END: lg.rd_kind = LOG_END;
         default: lg.rd_kind = LOG_HEADER;
      endcase
   end
endmodule

// ===== rtl/isv_supervisor.sv
`timescale 1ns/1ps
// Summary of operation
// - Short averaging: error after 10 s without a new value.
// - Long averaging: error when buffer holds under half the expected values.
// - Error with analog active forces outputs to min or max by select.
// - Error requests the error telegram and sets status error bits.
// - Auto heat on below 2 C or error lasting over 3 s.
// - Auto heat off 10 s after temperature above 7 C and error gone.
// - Mode zero holds heater off, mode two holds it on.
// - Aux pin level may permit or block heater when configured.
// - Hours counter in whole hours, wraps after about 11.4 years.
// - Mask weights: start 1, config 2, refs 4, data loss 8, low fill 16.
// - Events logged only when masked in, stamped with current hours.
// - Log query yields header, mask, events oldest first, end.
// - Every restart logs a system-start event.
// - Entering configuration mode logs an event.
// - 15 s without valid value re-acquires references and logs it.
// - No valid data for the set period logs data loss, then restarts.
// - Low-fill logged once below 2, re-armed only above 2.
// - Unlock then restart command restarts after about 3 s.
// - Nonzero mask lengthens boot by about 200 ms.
// - Aux function asserts pin when buffer fill above seven eighths.
// - Boot select 0 bus loader, 3 block-transfer CRC loader.
// - Loader first unless select 1 or 2; no peer starts firmware.
module isv_supervisor
   import isv_pkg::*;
#(
   parameter int TICK_CYCLES = TICK_CYCLES_DEF,
   parameter int BOOT_EXTRA_CYCLES = BOOT_EXTRA_CYCLES_DEF,
   parameter int LOG_DEPTH = 16,
   parameter int AVG_W = 16
)(
   input wire logic CLK,
   input wire logic ARST_N,
   input wire logic NEW_VALUE,
   input wire logic [AVG_W-1:0] AVERAGING_TIME,
   input wire logic [AVG_W-1:0] BUFFER_COUNT,
   input wire logic [2:0] FILL_OCTANT,
   input wire logic signed [15:0] VIRTUAL_TEMP_C10,
   input wire logic ANALOG_ACTIVE,
   input wire logic ERROR_LEVEL_SELECT,
   input wire logic ERROR_TELEGRAM_CONFIGURED,
   input wire logic [1:0] HEATER_MODE,
   input wire logic [1:0] AUX_PIN_FUNCTION,
   input wire logic AUX_GATE_ACTIVE_HIGH,
   input wire logic AUX_IO_PIN_IN,
   output logic AUX_IO_PIN_OUT,
   output logic AUX_IO_PIN_OE,
   input wire logic [EV_COUNT-1:0] EVENT_LOG_MASK,
   input wire logic CONFIG_MODE,
   input wire logic [AVG_W-1:0] NO_DATA_RESTART_PERIOD,
   input wire logic ACCESS_UNLOCK_COMMAND,
   input wire logic RESTART_COMMAND,
   input wire logic [2:0] BOOT_PATH_SELECT,
   input wire logic LOADER_PEER_FOUND,
   input wire logic LOADER_DONE,
   input wire logic EVENT_LOG_QUERY,
   input wire logic LOG_READY,
   output logic LOG_VALID,
   output logic [1:0] LOG_KIND,
   output logic [2:0] LOG_CODE,
   output logic [HOURS_W-1:0] LOG_HOURS,
   output logic [EV_COUNT-1:0] LOG_MASK_VALUE,
   output logic [HOURS_W-1:0] HOURS_COUNT,
   output logic ERROR_FLAG,
   output logic [1:0] STATUS_ERROR_BITS,
   output logic ANALOG_FORCE,
   output logic ANALOG_FORCE_MAX,
   output logic ERROR_TELEGRAM_REQ,
   output logic HEAT_CRITERION,
   output logic HEATER_ON,
   output logic REF_REACQUIRE,
   output logic LOADER_BUS_ACTIVE,
   output logic LOADER_XMODEM_ACTIVE,
   output logic APP_RUN
);
   localparam int TW = $clog2(TICK_CYCLES + 1);
   localparam int BW = $clog2(BOOT_EXTRA_CYCLES + 1);
   initial begin
      if (TICK_CYCLES < 1 || BOOT_EXTRA_CYCLES < 1) $error("Counts must be positive");
      if (AVG_W < 5 || AVG_W > 24) $error("AVG_W out of range");
   end
   function automatic logic [AVG_W-1:0] sat_inc(input logic [AVG_W-1:0] v);
      return (&v) ? v : v + 1'b1;
   endfunction
   // ----------------------------------------
   // Pin synchroniser and seconds tick
   // ----------------------------------------
   logic aux_meta_r, aux_sync_r;
   always_ff @(posedge CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         aux_meta_r <= 1'b0;
         aux_sync_r <= 1'b0;
      end else begin
         aux_meta_r <= AUX_IO_PIN_IN;
         aux_sync_r <= aux_meta_r;
      end
   end
   logic [TW-1:0] tick_cnt_r;
   logic tick;
   assign tick = (tick_cnt_r == TW'(TICK_CYCLES - 1));
   always_ff @(posedge CLK or negedge ARST_N) begin
      if (!ARST_N) tick_cnt_r <= '0;
      else tick_cnt_r <= tick ? '0 : tick_cnt_r + 1'b1;
   end
   // ----------------------------------------
   // Boot sequencer and restart
   // ----------------------------------------
   isv_boot_e boot_r;
   logic restart;
   logic unlocked_r;
   logic restart_pend_r;
   logic [1:0] restart_sec_r;
   logic nodata_restart;
   logic [BW-1:0] boot_cnt_r;
   always_ff @(posedge CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         unlocked_r <= 1'b0;
         restart_pend_r <= 1'b0;
         restart_sec_r <= '0;
      end else if (restart) begin
         unlocked_r <= 1'b0;
         restart_pend_r <= 1'b0;
         restart_sec_r <= '0;
      end else begin
         if (ACCESS_UNLOCK_COMMAND) unlocked_r <= 1'b1;
         if (RESTART_COMMAND && unlocked_r) restart_pend_r <= 1'b1;
         if (restart_pend_r && tick) restart_sec_r <= restart_sec_r + 1'b1;
      end
   end
   assign restart = (restart_pend_r && tick && restart_sec_r == 2'(RESTART_DELAY_SEC - 1))
                    || nodata_restart;
   always_ff @(posedge CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         boot_r <= ISV_BOOT_HOLD;
         boot_cnt_r <= '0;
      end else if (restart) begin
         boot_r <= ISV_BOOT_HOLD;
         boot_cnt_r <= '0;
      end else begin
         case (boot_r)
            ISV_BOOT_HOLD: boot_r <= (EVENT_LOG_MASK != '0) ? ISV_BOOT_DELAY : ISV_BOOT_LOADER;
            ISV_BOOT_DELAY: begin
               boot_cnt_r <= boot_cnt_r + 1'b1;
               if (boot_cnt_r == BW'(BOOT_EXTRA_CYCLES - 1)) boot_r <= ISV_BOOT_LOADER;
            end
            ISV_BOOT_LOADER: begin
               if (BOOT_PATH_SELECT == BOOT_FAST_1 || BOOT_PATH_SELECT == BOOT_FAST_2) boot_r <= ISV_BOOT_APP;
               else if (!LOADER_PEER_FOUND || LOADER_DONE) boot_r <= ISV_BOOT_APP;
            end
            ISV_BOOT_APP: boot_r <= ISV_BOOT_APP;
            default: boot_r <= ISV_BOOT_HOLD;
         endcase
      end
   end
   logic in_loader;
   assign in_loader = (boot_r == ISV_BOOT_LOADER) && BOOT_PATH_SELECT != BOOT_FAST_1
                      && BOOT_PATH_SELECT != BOOT_FAST_2;
   assign LOADER_BUS_ACTIVE = in_loader && BOOT_PATH_SELECT == BOOT_LOADER_BUS;
   assign LOADER_XMODEM_ACTIVE = in_loader && BOOT_PATH_SELECT == BOOT_LOADER_XMODEM;
   assign APP_RUN = (boot_r == ISV_BOOT_APP);
   // ----------------------------------------
   // Acquisition fault detection
   // ----------------------------------------
   logic [AVG_W-1:0] stale_sec_r;
   logic error_r;
   always_ff @(posedge CLK or negedge ARST_N) begin
      if (!ARST_N) stale_sec_r <= '0;
      else if (NEW_VALUE || restart) stale_sec_r <= '0;
      else if (tick) stale_sec_r <= sat_inc(stale_sec_r);
   end
   logic long_avg;
   assign long_avg = (AVERAGING_TIME >= AVG_W'(AVG_LONG_SEC));
   always_ff @(posedge CLK or negedge ARST_N) begin
      if (!ARST_N) error_r <= 1'b0;
      else if (!APP_RUN) error_r <= 1'b0;
      else if (long_avg) error_r <= ({BUFFER_COUNT, 1'b0} < {1'b0, AVERAGING_TIME});
      else error_r <= (stale_sec_r >= AVG_W'(NO_VALUE_SEC));
   end
   assign ERROR_FLAG = error_r;
   assign STATUS_ERROR_BITS = {1'b0, error_r};
   assign ERROR_TELEGRAM_REQ = error_r && ERROR_TELEGRAM_CONFIGURED;
   assign ANALOG_FORCE = error_r && ANALOG_ACTIVE;
   assign ANALOG_FORCE_MAX = ERROR_LEVEL_SELECT;
   // ----------------------------------------
   // Heating controller
   // ----------------------------------------
   logic [2:0] err_sec_r;
   logic [3:0] off_sec_r;
   logic auto_heat_r;
   logic heat_crit;
   logic off_cond;
   assign heat_crit = (VIRTUAL_TEMP_C10 < HEAT_ON_TEMP_C10) || (err_sec_r > 3'(ERR_HEAT_SEC));
   // Both conditions required; either alone keeps heating
   assign off_cond = (VIRTUAL_TEMP_C10 > HEAT_OFF_TEMP_C10) && !error_r;
   always_ff @(posedge CLK or negedge ARST_N) begin
      if (!ARST_N) err_sec_r <= '0;
      else if (!error_r) err_sec_r <= '0;
      else if (tick && err_sec_r != 3'h7) err_sec_r <= err_sec_r + 1'b1;
   end
   always_ff @(posedge CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         auto_heat_r <= 1'b0;
         off_sec_r <= '0;
      end else if (heat_crit) begin
         auto_heat_r <= 1'b1;
         off_sec_r <= '0;
      end else if (!off_cond) begin
         off_sec_r <= '0;
      end else if (auto_heat_r && tick) begin
         if (off_sec_r == 4'(HEAT_OFF_SEC - 1)) begin
            auto_heat_r <= 1'b0;
            off_sec_r <= '0;
         end else begin
            off_sec_r <= off_sec_r + 1'b1;
         end
      end
   end
   logic heat_permit;
   assign heat_permit = (AUX_PIN_FUNCTION != AUX_HEAT_GATE) || (aux_sync_r == AUX_GATE_ACTIVE_HIGH);
   logic heat_want;
   always_comb begin
      case (HEATER_MODE)
         HEAT_OFF: heat_want = 1'b0;
         HEAT_AUTO: heat_want = auto_heat_r;
         HEAT_ON: heat_want = 1'b1;
         default: heat_want = 1'b0;
      endcase
   end
   always_ff @(posedge CLK or negedge ARST_N) begin
      if (!ARST_N) HEATER_ON <= 1'b0;
      else HEATER_ON <= heat_want && heat_permit;
   end
   assign HEAT_CRITERION = heat_crit;
   // ----------------------------------------
   // Aux pin full flag
   // ----------------------------------------
   // Host must keep averaging time at 600 ms or more here
   always_ff @(posedge CLK or negedge ARST_N) begin
      if (!ARST_N) AUX_IO_PIN_OUT <= 1'b0;
      else AUX_IO_PIN_OUT <= (FILL_OCTANT == FILL_FULL_LIMIT);
   end
   assign AUX_IO_PIN_OE = (AUX_PIN_FUNCTION == AUX_FULL_FLAG);
   // ----------------------------------------
   // Operating hours
   // ----------------------------------------
   logic [11:0] sec_in_hour_r;
   logic [HOURS_W-1:0] hours_r;
   always_ff @(posedge CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         sec_in_hour_r <= '0;
         hours_r <= '0;
      end else if (tick) begin
         if (sec_in_hour_r == 12'(SECONDS_PER_HOUR - 1)) begin
            sec_in_hour_r <= '0;
            hours_r <= (hours_r == HOURS_W'(HOURS_WRAP - 1)) ? '0 : hours_r + 1'b1;
         end else begin
            sec_in_hour_r <= sec_in_hour_r + 1'b1;
         end
      end
   end
   assign HOURS_COUNT = hours_r;
   // ----------------------------------------
   // Event sources
   // ----------------------------------------
   logic [EV_COUNT-1:0] ev_pend_r;
   logic [EV_COUNT-1:0] ev_raise;
   logic cfg_d_r, low_armed_r, boot_seen_r;
   logic ref_fire, nodata_fire;
   assign ref_fire = APP_RUN && tick && stale_sec_r == AVG_W'(REF_REACQ_SEC - 1);
   assign nodata_fire = APP_RUN && tick && NO_DATA_RESTART_PERIOD != '0
                        && stale_sec_r == NO_DATA_RESTART_PERIOD - 1'b1;
   always_ff @(posedge CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         cfg_d_r <= 1'b0;
         low_armed_r <= 1'b1;
         boot_seen_r <= 1'b0;
         REF_REACQUIRE <= 1'b0;
         nodata_restart <= 1'b0;
      end else begin
         cfg_d_r <= CONFIG_MODE;
         boot_seen_r <= !restart && (boot_seen_r || boot_r == ISV_BOOT_HOLD);
         REF_REACQUIRE <= ref_fire;
         nodata_restart <= nodata_fire;
         if (FILL_OCTANT < FILL_LOW_LIMIT) low_armed_r <= 1'b0;
         else if (FILL_OCTANT > FILL_LOW_LIMIT) low_armed_r <= 1'b1;
      end
   end
   always_comb begin
      ev_raise = '0;
      ev_raise[EV_START] = (boot_r == ISV_BOOT_HOLD) && !boot_seen_r;
      ev_raise[EV_CONFIG] = CONFIG_MODE && !cfg_d_r;
      ev_raise[EV_REFREG] = ref_fire;
      ev_raise[EV_NODATA] = nodata_fire;
      ev_raise[EV_LOWFILL] = low_armed_r && (FILL_OCTANT < FILL_LOW_LIMIT);
   end
   // ----------------------------------------
   // Log writer, one event per cycle
   // ----------------------------------------
   logic [2:0] wr_sel;
   logic wr_any;
   always_comb begin
      wr_sel = 3'h0;
      wr_any = 1'b0;
      for (int i = EV_COUNT - 1; i >= 0; i--) begin
         if (ev_pend_r[i]) begin
            wr_sel = 3'(i);
            wr_any = 1'b1;
         end
      end
   end
   always_ff @(posedge CLK or negedge ARST_N) begin
      if (!ARST_N) ev_pend_r <= '0;
      else ev_pend_r <= (ev_pend_r & ~(wr_any ? (EV_COUNT'(1) << wr_sel) : '0))
                        | (ev_raise & EVENT_LOG_MASK);
   end
   isv_log_if #(.HOURS_W(HOURS_W)) lg();
   assign lg.wr_en = wr_any;
   assign lg.wr_code = wr_sel;
   assign lg.wr_hours = hours_r;
   assign lg.rd_start = EVENT_LOG_QUERY;
   assign lg.rd_ready = LOG_READY;
   isv_event_log #(.DEPTH(LOG_DEPTH)) u_log (
      .clk(CLK),
      .arst_n(ARST_N),
      .lg(lg.store)
   );
   assign LOG_VALID = lg.rd_valid;
   assign LOG_KIND = lg.rd_kind;
   assign LOG_CODE = lg.rd_code;
   assign LOG_HOURS = lg.rd_hours;
   assign LOG_MASK_VALUE = EVENT_LOG_MASK;
endmodule

// ===== tb/isv_supervisor_assertions.sv
`timescale 1ns/1ps
module isv_supervisor_assertions
   import isv_pkg::*;
(
   input wire logic CLK,
   input wire logic ARST_N,
   input wire logic [2:0] FILL_OCTANT,
   input wire logic signed [15:0] VIRTUAL_TEMP_C10,
   input wire logic ANALOG_ACTIVE,
   input wire logic ERROR_LEVEL_SELECT,
   input wire logic ERROR_TELEGRAM_CONFIGURED,
   input wire logic [1:0] HEATER_MODE,
   input wire logic [1:0] AUX_PIN_FUNCTION,
   input wire logic LOG_READY,
   input wire logic AUX_IO_PIN_OUT,
   input wire logic LOG_VALID,
   input wire logic [1:0] LOG_KIND,
   input wire logic ERROR_FLAG,
   input wire logic [1:0] STATUS_ERROR_BITS,
   input wire logic ANALOG_FORCE,
   input wire logic ANALOG_FORCE_MAX,
   input wire logic ERROR_TELEGRAM_REQ,
   input wire logic HEATER_ON,
   input wire logic REF_REACQUIRE
);
   default clocking dc @(posedge CLK);
   endclocking
   default disable iff (!ARST_N);
   // ----------------
   // Error reporting and reacquire pulse
   // ----------------
   property p_force;
      ANALOG_FORCE == (ERROR_FLAG && ANALOG_ACTIVE);
   endproperty
   a_force: assert property (p_force) else $error("analog force mismatch");
   property p_level;
      ANALOG_FORCE |-> ANALOG_FORCE_MAX == ERROR_LEVEL_SELECT;
   endproperty
   a_level: assert property (p_level) else $error("forced level mismatch");
   property p_report;
      ERROR_TELEGRAM_REQ == (ERROR_FLAG && ERROR_TELEGRAM_CONFIGURED) && STATUS_ERROR_BITS == {1'b0, ERROR_FLAG};
   endproperty
   a_report: assert property (p_report) else $error("error report mismatch");
   property p_ref_pulse;
      REF_REACQUIRE |=> !REF_REACQUIRE;
   endproperty
   a_ref_pulse: assert property (p_ref_pulse) else $error("reacquire pulse too long");
   // ----------------
   // Heater, pin and log read-out
   // ----------------
   property p_heat_off;
      HEATER_MODE != HEAT_AUTO && HEATER_MODE != HEAT_ON |=> !HEATER_ON;
   endproperty
   a_heat_off: assert property (p_heat_off) else $error("heater on in off mode");
   property p_heat_cold;
      (HEATER_MODE == HEAT_AUTO && VIRTUAL_TEMP_C10 < HEAT_ON_TEMP_C10 && AUX_PIN_FUNCTION != AUX_HEAT_GATE)[*2]
         |=> HEATER_ON;
   endproperty
   a_heat_cold: assert property (p_heat_cold) else $error("heater off when cold");
   property p_full_pin;
      ARST_N |=> AUX_IO_PIN_OUT == ($past(FILL_OCTANT) == FILL_FULL_LIMIT);
   endproperty
   a_full_pin: assert property (p_full_pin) else $error("full pin mismatch");
   property p_log_walk;
      LOG_VALID && LOG_KIND == LOG_HEADER && LOG_READY |=> LOG_VALID && LOG_KIND == LOG_MASK;
   endproperty
   a_log_walk: assert property (p_log_walk) else $error("mask line not after header");
   c_err: cover property (ERROR_FLAG && ANALOG_FORCE);
   c_heat: cover property (HEATER_ON);
   c_log: cover property (LOG_VALID && LOG_KIND == LOG_END && LOG_READY);
endmodule
bind isv_supervisor isv_supervisor_assertions u_chk (.*);

// ===== tb/isv_host_model.sv
`timescale 1ns/1ps
module isv_host_model
   import isv_pkg::*;
(
   input wire logic clk,
   output logic unlock,
   output logic restart,
   output logic query,
   output logic ready,
   input wire logic log_valid,
   input wire logic [1:0] log_kind,
   input wire logic [2:0] log_code
);
   logic [1:0] kinds[$];
   logic [2:0] codes[$];
   initial begin
      unlock = 1'b0;
      restart = 1'b0;
      query = 1'b0;
      ready = 1'b0;
   end
   // Lone restart is used to probe refusal
   task automatic send_restart(input logic with_unlock);
      if (with_unlock) begin
         @(posedge clk) unlock <= 1'b1;
         @(posedge clk) unlock <= 1'b0;
      end
      @(posedge clk) restart <= 1'b1;
      @(posedge clk) restart <= 1'b0;
   endtask
   // Slow host drops ready every other cycle
   task automatic read_log(input logic stall);
      kinds = {};
      codes = {};
      @(posedge clk) query <= 1'b1;
      @(posedge clk) query <= 1'b0;
      for (int n = 0; n < 200; n++) begin
         @(posedge clk);
         if (log_valid === 1'b1 && ready === 1'b1) begin
            kinds.push_back(log_kind);
            codes.push_back(log_code);
            if (log_kind === LOG_END) break;
         end
         ready <= !stall || n[0];
      end
      ready <= 1'b0;
   endtask
endmodule

// ===== tb/isv_supervisor_bench.sv
`timescale 1ns/1ps
module isv_supervisor_bench;
   import isv_pkg::*;
   localparam int TK = 10;
   localparam int EX = 5;
   logic clk = 1'b0, arst_n = 1'b0, nv = 1'b0, feed = 1'b1, cfg = 1'b0, aux_in = 1'b0, aa = 1'b1, els = 1'b1;
   logic peer = 1'b1, ld_done = 1'b0, unl, rst_cmd, qry, rdy;
   logic [15:0] avg = 16'h0005, bufc = 16'h0005, rfp = 16'h0000;
   logic signed [15:0] temp = 16'sh00C8;
   logic [2:0] fill = 3'h7, bsel = BOOT_FAST_1;
   logic [1:0] hmode = HEAT_OFF, afn = AUX_NONE;
   logic [4:0] mask = 5'h13;
   logic aout, aoe, lv, ef, af, afm, treq, hon, rr, lb, lx, app, hc;
   logic [1:0] lk, sb;
   logic [2:0] lc;
   logic [4:0] mv;
   logic [16:0] hrs;
   logic [2:0] fl[6] = '{3'h1, 3'h2, 3'h1, 3'h3, 3'h1, 3'h7};
   logic [2:0] bs[4] = '{BOOT_LOADER_BUS, BOOT_FAST_1, BOOT_FAST_2, BOOT_LOADER_XMODEM};
   logic [1:0] hm[4] = '{HEAT_OFF, HEAT_AUTO, HEAT_ON, 2'h3};
   logic [1:0] ek[7] = '{LOG_HEADER, LOG_MASK, LOG_ENTRY, LOG_ENTRY, LOG_ENTRY, LOG_ENTRY, LOG_END};
   int ec[4] = '{EV_START, EV_CONFIG, EV_LOWFILL, EV_LOWFILL};
   int err_count = 0, total_checks = 0, cyc = 0, c0, n0, n1, t;
   isv_supervisor #(.TICK_CYCLES(TK), .BOOT_EXTRA_CYCLES(EX)) dut (
      .CLK(clk), .ARST_N(arst_n), .NEW_VALUE(nv), .AVERAGING_TIME(avg), .BUFFER_COUNT(bufc),
      .FILL_OCTANT(fill), .VIRTUAL_TEMP_C10(temp), .ANALOG_ACTIVE(aa), .ERROR_LEVEL_SELECT(els),
      .ERROR_TELEGRAM_CONFIGURED(1'b1), .HEATER_MODE(hmode), .AUX_PIN_FUNCTION(afn),
      .AUX_GATE_ACTIVE_HIGH(1'b1), .AUX_IO_PIN_IN(aoe ? aout : aux_in), .AUX_IO_PIN_OUT(aout),
      .AUX_IO_PIN_OE(aoe), .EVENT_LOG_MASK(mask), .CONFIG_MODE(cfg), .NO_DATA_RESTART_PERIOD(rfp),
      .ACCESS_UNLOCK_COMMAND(unl), .RESTART_COMMAND(rst_cmd), .BOOT_PATH_SELECT(bsel),
      .LOADER_PEER_FOUND(peer), .LOADER_DONE(ld_done), .EVENT_LOG_QUERY(qry), .LOG_READY(rdy),
      .LOG_VALID(lv), .LOG_KIND(lk), .LOG_CODE(lc), .LOG_HOURS(), .LOG_MASK_VALUE(mv),
      .HOURS_COUNT(hrs), .ERROR_FLAG(ef), .STATUS_ERROR_BITS(sb), .ANALOG_FORCE(af),
      .ANALOG_FORCE_MAX(afm), .ERROR_TELEGRAM_REQ(treq), .HEAT_CRITERION(hc), .HEATER_ON(hon),
      .REF_REACQUIRE(rr), .LOADER_BUS_ACTIVE(lb), .LOADER_XMODEM_ACTIVE(lx), .APP_RUN(app));
   isv_host_model host (.clk(clk), .unlock(unl), .restart(rst_cmd), .query(qry), .ready(rdy),
      .log_valid(lv), .log_kind(lk), .log_code(lc));
   initial forever #4 clk = ~clk;
   // ----------------
   // Tasks
   // ----------------
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         err_count++;
         $display("wrong value at %0t: got %0h expected %0h", $time, got, exp);
      end
   endtask
   task automatic wt(ref logic s, input logic v, input int lim, output int n);
      n = 0;
      while (s !== v && n < lim) begin
         @(posedge clk);
         n++;
      end
      chk(s, v);
   endtask
   task automatic summarize();
      $display("checks %0d mismatches %0d", total_checks, err_count);
      if (err_count == 0 && total_checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   // One value per tick while feeding; hang guard
   always @(posedge clk) begin
      cyc <= cyc + 1;
      nv <= feed && (cyc % TK == 0);
      if (cyc == 60000) begin
         err_count++;
         summarize();
      end
   end
   // ----------------
   // Sequence
   // ----------------
   initial begin
      repeat (3) @(posedge clk);
      arst_n <= 1'b1;
      c0 = cyc;
      wt(app, 1'b1, 100, n1);
      cfg <= 1'b1;
      foreach (fl[i]) begin
         @(posedge clk) fill <= fl[i];
         repeat (3) @(posedge clk);
      end
      host.read_log(1'b1);
      chk(host.kinds.size(), 7);
      foreach (ek[i]) chk(host.kinds[i], ek[i]);
      foreach (ec[i]) chk(host.codes[i + 2], ec[i]);
      chk(mv, 5'h13);
      mask <= 5'h00;
      foreach (bs[i]) begin
         bsel <= bs[i];
         host.send_restart(1'b1);
         wt(app, 1'b0, 5 * TK, t);
         chk(t inside {[2 * TK:4 * TK]}, 1'b1);
         if (bs[i] == BOOT_LOADER_BUS) wt(lb, 1'b1, 10, t);
         else if (bs[i] == BOOT_LOADER_XMODEM) wt(lx, 1'b1, 10, t);
         else wt(app, 1'b1, 10, n0);
         ld_done <= 1'b1;
         @(posedge clk);
         wt(app, 1'b1, 10, t);
         ld_done <= 1'b0;
      end
      chk((n1 - n0 - EX) inside {[0:3]}, 1'b1);
      host.send_restart(1'b0);
      repeat (5 * TK) @(posedge clk);
      chk(app, 1'b1);
      hmode <= HEAT_AUTO;
      feed <= 1'b0;
      repeat (8 * TK) @(posedge clk);
      chk(ef, 1'b0);
      wt(ef, 1'b1, 4 * TK, t);
      chk({af, afm, treq, sb}, 5'h1D);
      {aa, els} <= 2'h0;
      @(posedge clk);
      chk({af, afm, treq}, 3'h1);
      wt(hon, 1'b1, 5 * TK, t);
      chk(hc, 1'b1);
      wt(rr, 1'b1, 8 * TK, t);
      feed <= 1'b1;
      wt(ef, 1'b0, 3 * TK, t);
      repeat (8 * TK) @(posedge clk);
      chk(hon, 1'b1);
      wt(hon, 1'b0, 4 * TK, t);
      avg <= 16'h0014;
      bufc <= 16'h0009;
      wt(ef, 1'b1, 3 * TK, t);
      bufc <= 16'h000A;
      wt(ef, 1'b0, 3 * TK, t);
      avg <= 16'h0005;
      mask <= 5'h08;
      rfp <= 16'h0003;
      peer <= 1'b0;
      feed <= 1'b0;
      wt(app, 1'b0, 6 * TK, t);
      feed <= 1'b1;
      rfp <= 16'h0000;
      wt(app, 1'b1, 20, t);
      host.read_log(1'b0);
      chk(host.codes[host.codes.size() - 2], EV_NODATA);
      // Gate pin low blocks heating even when cold
      temp <= 16'sh0000;
      afn <= AUX_HEAT_GATE;
      repeat (5) @(posedge clk);
      chk(hon, 1'b0);
      aux_in <= 1'b1;
      wt(hon, 1'b1, 6, t);
      afn <= AUX_NONE;
      foreach (hm[i]) begin
         hmode <= hm[i];
         repeat (2) @(posedge clk);
         chk(hon, hm[i] == HEAT_AUTO || hm[i] == HEAT_ON);
      end
      afn <= AUX_FULL_FLAG;
      fill <= 3'h6;
      repeat (2) @(posedge clk);
      chk({aoe, aout}, 2'h2);
      fill <= 3'h7;
      repeat (2) @(posedge clk);
      chk({aoe, aout}, 2'h3);
      while (hrs !== 17'h00001 && cyc < 50000) @(posedge clk);
      chk((cyc - c0) inside {[3599 * TK:3601 * TK]}, 1'b1);
      summarize();
   end
endmodule
